/* hw/smbus_target.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tsense_params.svh"
module smbus_target #(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe_o,
  input  wire logic [7:0]               rd_data_i,
  input  wire logic                     alert_req_i,
  output tsense_pkg::reg_access_t       acc_o
);
  tsense_pkg::bus_regs_t s;
  tsense_pkg::bus_regs_t next_s;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic dev_hit;
  logic ara_hit;

  assign start   = s.scl_q & scl_i & s.sda_q & ~sda_i;
  assign stop    = s.scl_q & scl_i & ~s.sda_q & sda_i;
  assign rise    = ~s.scl_q & scl_i;
  assign fall    = s.scl_q & ~scl_i;
  assign dev_hit = s.sh[7:1] == DEV_ADDR;
  // Only a device whose alert is pending answers the alert response address.
  assign ara_hit = (s.sh[7:1] == `ARA_ADDR) & s.sh[0] & alert_req_i;

  always_comb begin
    next_s          = s;
    next_s.scl_q    = scl_i;
    next_s.sda_q    = sda_i;
    next_s.wr_stb   = 1'b0;
    next_s.rd_stb   = 1'b0;
    next_s.ara_done = 1'b0;
    if (start) begin
      next_s.st    = tsense_pkg::BUS_ADDR;
      next_s.cnt   = 4'h0;
      next_s.drive = 1'b0;
    end else if (stop) begin
      next_s.st    = tsense_pkg::BUS_IDLE;
      next_s.drive = 1'b0;
    end else begin
      unique case (s.st)
        tsense_pkg::BUS_IDLE: begin
        end
        tsense_pkg::BUS_ADDR, tsense_pkg::BUS_WR: begin
          if (rise) begin
            next_s.sh  = {s.sh[6:0], sda_i};
            next_s.cnt = s.cnt + 4'h1;
          end else if (fall && s.cnt == 4'h8 && s.st == tsense_pkg::BUS_ADDR) begin
            if (dev_hit || ara_hit) begin
              next_s.drive = 1'b1;
              next_s.st    = tsense_pkg::BUS_ACK_ADDR;
              next_s.rw    = s.sh[0];
              next_s.ara   = ~dev_hit;
            end else begin
              next_s.st = tsense_pkg::BUS_IDLE;
            end
            next_s.first = 1'b1;
          end else if (fall && s.cnt == 4'h8) begin
            next_s.drive = 1'b1;
            next_s.st    = tsense_pkg::BUS_ACK_WR;
            next_s.first = 1'b0;
            if (s.first) begin
              next_s.ptr = s.sh;
            end else begin
              next_s.wr_stb = 1'b1;
            end
          end
        end
        tsense_pkg::BUS_ACK_ADDR: begin
          if (fall) begin
            next_s.cnt = 4'h0;
            if (s.rw) begin
              next_s.sh     = s.ara ? {DEV_ADDR, 1'b0} : rd_data_i;
              next_s.rd_stb = ~s.ara;
              next_s.drive  = ~next_s.sh[7];
              next_s.st     = tsense_pkg::BUS_RD;
            end else begin
              next_s.drive = 1'b0;
              next_s.st    = tsense_pkg::BUS_WR;
            end
          end
        end
        tsense_pkg::BUS_ACK_WR: begin
          if (fall) begin
            next_s.drive = 1'b0;
            next_s.cnt   = 4'h0;
            next_s.st    = tsense_pkg::BUS_WR;
          end
        end
        tsense_pkg::BUS_RD: begin
          if (rise) begin
            next_s.cnt = s.cnt + 4'h1;
          end else if (fall && s.cnt == 4'h8) begin
            next_s.drive = 1'b0;
            next_s.st    = tsense_pkg::BUS_ACK_RD;
          end else if (fall) begin
            next_s.sh    = {s.sh[6:0], 1'b0};
            next_s.drive = ~s.sh[6];
          end
        end
        tsense_pkg::BUS_ACK_RD: begin
          if (rise && (sda_i || s.ara)) begin
            next_s.ara_done = s.ara;
            next_s.st       = tsense_pkg::BUS_IDLE;
          end else if (rise) begin
            next_s.st = tsense_pkg::BUS_ACK_ADDR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s       <= '0;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = s.drive;
  assign acc_o    = '{wr_stb: s.wr_stb, rd_stb: s.rd_stb, ara_done: s.ara_done, ptr: s.ptr, wr_data: s.sh};
endmodule : smbus_target
`default_nettype wire

/* hw/standby_and_sensor_fault_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tsense_params.svh"
module standby_and_sensor_fault_ctrl #(
  parameter logic [15:0] CONV_GAP = `CONV_GAP,
  parameter logic [6:0]  DEV_ADDR = `DEV_ADDR
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       low_power_hold_n_i,
  input  wire logic       scl_i,
  input  wire logic       serial_data_line_i,
  output logic            serial_data_line_o,
  output logic            serial_data_line_oe_o,
  output logic            alert_o,
  output logic            alert_oe_o,
  output logic            adc_start_o,
  output logic            adc_channel_o,
  output logic            adc_abort_o,
  input  wire logic       adc_done_i,
  input  wire logic [7:0] adc_code_i,
  input  wire logic       adc_under_range_i,
  input  wire logic       open_cmp_i
);
  tsense_pkg::ctrl_regs_t  s;
  tsense_pkg::ctrl_regs_t  next_s;
  tsense_pkg::reg_access_t acc;
  logic [7:0] rd_data;
  logic       hw_hold;
  logic       sw_hold;
  logic       standby;
  logic       go;
  logic       kill;
  logic       c_lhi;
  logic       c_llo;
  logic       c_rhi;
  logic       c_rlo;
  logic       cond_any;

  function automatic logic [7:0] read_reg(input logic [7:0] ptr, input tsense_pkg::ctrl_regs_t r);
    unique case (ptr)
      `REG_LOCAL:  read_reg = r.local_val;
      `REG_REMOTE: read_reg = r.remote_val;
      `REG_STATUS: read_reg = r.status;
      `REG_CFG:    read_reg = r.cfg;
      `REG_LHI:    read_reg = r.lhi;
      `REG_LLO:    read_reg = r.llo;
      `REG_RHI:    read_reg = r.rhi;
      `REG_RLO:    read_reg = r.rlo;
      default:     read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // The serial slave is never gated by standby.
  smbus_target #(
    .DEV_ADDR (DEV_ADDR)
  ) u_bus (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .scl_i       (scl_i),
    .sda_i       (serial_data_line_i),
    .sda_o       (serial_data_line_o),
    .sda_oe_o    (serial_data_line_oe_o),
    .rd_data_i   (rd_data),
    .alert_req_i (s.alert),
    .acc_o       (acc)
  );

  assign rd_data  = read_reg(acc.ptr, s);
  assign hw_hold  = ~low_power_hold_n_i;
  assign sw_hold  = s.cfg[`CFG_HOLD_BIT];
  assign standby  = hw_hold | sw_hold;
  // A hold pin low wins over any pending one-shot request.
  assign go       = (s.seq == tsense_pkg::SEQ_IDLE) & ~hw_hold &
                    ((~sw_hold & (s.gap == 16'h0000)) | (sw_hold & s.os_pend));
  assign kill     = hw_hold | (sw_hold & ~s.os_run);
  assign c_lhi    = $signed(s.local_val) > $signed(s.lhi);
  assign c_llo    = $signed(s.local_val) < $signed(s.llo);
  assign c_rhi    = $signed(s.remote_val) > $signed(s.rhi);
  // A limit of 80h can never be undercut, which is how an unused channel is silenced.
  assign c_rlo    = $signed(s.remote_val) < $signed(s.rlo);
  assign cond_any = c_lhi | c_llo | c_rhi | c_rlo | s.status[`ST_OPEN];

  always_comb begin
    next_s       = s;
    next_s.start = 1'b0;
    next_s.abort = 1'b0;
    if (acc.wr_stb) begin
      unique case (acc.ptr)
        `REG_CFG:     next_s.cfg = acc.wr_data;
        `REG_LHI:     next_s.lhi = acc.wr_data;
        `REG_LLO:     next_s.llo = acc.wr_data;
        `REG_RHI:     next_s.rhi = acc.wr_data;
        `REG_RLO:     next_s.rlo = acc.wr_data;
        `REG_ONESHOT: next_s.os_pend = s.os_pend | (sw_hold & ~hw_hold);
        default:      next_s.cfg = s.cfg;
      endcase
    end
    // Clearing on read comes first so that a same-cycle event still lands.
    if (acc.rd_stb && acc.ptr == `REG_STATUS) begin
      next_s.status = 8'h00;
    end
    next_s.status[`ST_LHI] = next_s.status[`ST_LHI] | c_lhi;
    next_s.status[`ST_LLO] = next_s.status[`ST_LLO] | c_llo;
    next_s.status[`ST_RHI] = next_s.status[`ST_RHI] | c_rhi;
    next_s.status[`ST_RLO] = next_s.status[`ST_RLO] | c_rlo;
    unique case (s.seq)
      tsense_pkg::SEQ_IDLE: begin
        if (s.gap != 16'h0000) begin
          next_s.gap = s.gap - 16'h0001;
        end
        if (go) begin
          next_s.start   = 1'b1;
          next_s.chan    = 1'b0;
          next_s.seq     = tsense_pkg::SEQ_LOCAL;
          next_s.os_run  = sw_hold;
          next_s.os_pend = 1'b0;
          next_s.status[`ST_OPEN] = next_s.status[`ST_OPEN] | open_cmp_i;
        end
      end
      tsense_pkg::SEQ_LOCAL, tsense_pkg::SEQ_REMOTE: begin
        if (kill) begin
          next_s.abort  = 1'b1;
          next_s.seq    = tsense_pkg::SEQ_IDLE;
          next_s.os_run = 1'b0;
        end else if (adc_done_i && s.seq == tsense_pkg::SEQ_LOCAL) begin
          next_s.local_val = adc_code_i;
          next_s.start     = 1'b1;
          next_s.chan      = 1'b1;
          next_s.seq       = tsense_pkg::SEQ_REMOTE;
        end else if (adc_done_i) begin
          next_s.remote_val = adc_under_range_i ? `SHORT_CODE : adc_code_i;
          next_s.seq        = tsense_pkg::SEQ_IDLE;
          next_s.os_run     = 1'b0;
          next_s.gap        = CONV_GAP;
        end
      end
    endcase
    // The latch holds the pin low until an alert response finds the cause gone.
    next_s.alert = cond_any | (s.alert & ~acc.ara_done);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s     <= '0;
      s.lhi <= `LIM_HI_RST;
      s.llo <= `LIM_LO_RST;
      s.rhi <= `LIM_HI_RST;
      s.rlo <= `LIM_LO_RST;
    end else begin
      s <= next_s;
    end
  end

  assign alert_o       = 1'b0;
  assign alert_oe_o    = s.alert;
  assign adc_start_o   = s.start;
  assign adc_channel_o = s.chan;
  assign adc_abort_o   = s.abort;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_NORMAL_STARTS: assert property (
    (!standby && s.seq == tsense_pkg::SEQ_IDLE && s.gap == 16'h0000) |=> adc_start_o && !adc_channel_o)
    else $error("Idle normal mode did not start a conversion.");
  AST_ABORT_KEEPS: assert property (
    (s.seq != tsense_pkg::SEQ_IDLE && hw_hold) |=>
      adc_abort_o && s.seq == tsense_pkg::SEQ_IDLE && $stable(s.local_val) && $stable(s.remote_val))
    else $error("Standby entry did not abort cleanly.");
  AST_BUS_IN_STANDBY: assert property (
    (standby && acc.wr_stb && acc.ptr == `REG_LHI) |=> s.lhi == $past(acc.wr_data))
    else $error("Register write lost during standby.");
  AST_HOLD_BLOCKS: assert property (
    hw_hold |=> !adc_start_o)
    else $error("Conversion started while hold pin low.");
  AST_ONESHOT_RUNS: assert property (
    (acc.wr_stb && acc.ptr == `REG_ONESHOT && sw_hold && !hw_hold && s.seq == tsense_pkg::SEQ_IDLE)
      ##1 (sw_hold && !hw_hold) |=> adc_start_o)
    else $error("One-shot write did not start a conversion.");
  AST_OPEN_SAMPLED: assert property (
    (go && open_cmp_i) |=> s.status[`ST_OPEN])
    else $error("Open sensor not flagged at conversion start.");
  AST_SHORT_CODE: assert property (
    (s.seq == tsense_pkg::SEQ_REMOTE && adc_done_i && adc_under_range_i && !kill)
      |=> s.remote_val == `SHORT_CODE)
    else $error("Under-range reading not stored as 80h.");
  AST_RLO_RESET: assert property (
    $fell(rst_i) |-> s.rlo == `LIM_LO_RST && !alert_oe_o)
    else $error("Remote low limit reset value wrong.");
  AST_BELOW_LIMIT_ALERTS: assert property (
    c_rlo |=> alert_oe_o ##1 alert_oe_o)
    else $error("Reading below low limit did not alert.");
  AST_ALERT_ON_COND: assert property (
    cond_any |=> alert_oe_o && !alert_o)
    else $error("Alarm pin not driven low on a fault.");
  AST_ARA_RELEASE: assert property (
    (acc.ara_done && !cond_any) |=> !alert_oe_o)
    else $error("Alarm not released after alert response.");
  AST_ARA_HOLD: assert property (
    (s.alert && !acc.ara_done) |=> alert_oe_o)
    else $error("Alarm released without alert response.");
  AST_ONESHOT_ENDS: assert property (
    (s.seq == tsense_pkg::SEQ_REMOTE && s.os_run && adc_done_i && !kill)
      |=> s.seq == tsense_pkg::SEQ_IDLE && !s.os_run)
    else $error("One-shot did not return to idle.");

  COV_ONESHOT: cover property (sw_hold && !hw_hold && adc_start_o);
  COV_ABORT: cover property (adc_abort_o);
  COV_ARA: cover property (acc.ara_done);
  COV_SHORT: cover property (s.remote_val == `SHORT_CODE && alert_oe_o);
endmodule : standby_and_sensor_fault_ctrl
`default_nettype wire

/* pkg/tsense_params.svh */
`ifndef TSENSE_PARAMS_SVH
`define TSENSE_PARAMS_SVH
`define REG_LOCAL    8'h00
`define REG_REMOTE   8'h01
`define REG_STATUS   8'h02
`define REG_CFG      8'h03
`define REG_LHI      8'h04
`define REG_LLO      8'h05
`define REG_RHI      8'h06
`define REG_RLO      8'h07
`define REG_ONESHOT  8'h0F
`define CFG_HOLD_BIT 6
`define ST_OPEN      2
`define ST_RLO       3
`define ST_RHI       4
`define ST_LLO       5
`define ST_LHI       6
`define LIM_HI_RST   8'h7F
`define LIM_LO_RST   8'hC9
`define SHORT_CODE   8'h80
`define ARA_ADDR     7'h0C
`define DEV_ADDR     7'h2A
`define CONV_GAP     16'h0010
`endif

/* pkg/tsense_pkg.sv */
`default_nettype none
package tsense_pkg;
  typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_WR, BUS_ACK_WR, BUS_RD, BUS_ACK_RD} bus_state_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOCAL, SEQ_REMOTE} seq_state_t;
  typedef struct packed {
    logic       wr_stb;
    logic       rd_stb;
    logic       ara_done;
    logic [7:0] ptr;
    logic [7:0] wr_data;
  } reg_access_t;
  typedef struct packed {
    bus_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       rw;
    logic       ara;
    logic       first;
    logic [7:0] ptr;
    logic       drive;
    logic       scl_q;
    logic       sda_q;
    logic       wr_stb;
    logic       rd_stb;
    logic       ara_done;
  } bus_regs_t;
  typedef struct packed {
    seq_state_t  seq;
    logic        os_pend;
    logic        os_run;
    logic [15:0] gap;
    logic        start;
    logic        abort;
    logic        chan;
    logic        alert;
    logic [7:0]  local_val;
    logic [7:0]  remote_val;
    logic [7:0]  cfg;
    logic [7:0]  lhi;
    logic [7:0]  llo;
    logic [7:0]  rhi;
    logic [7:0]  rlo;
    logic [7:0]  status;
  } ctrl_regs_t;
endpackage : tsense_pkg
`default_nettype wire

/* test/converter_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side: converter plus remote diode. Outside a done pulse the code and range lines
// carry a changing pattern, so a design that samples them late sees garbage.
module converter_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       channel_i,
  input  wire logic       abort_i,
  input  wire logic [7:0] local_code_i,
  input  wire logic [7:0] remote_code_i,
  input  wire logic       short_i,
  input  wire logic [4:0] delay_i,
  output logic            done_o,
  output logic [7:0]      code_o,
  output logic            under_o
);
  logic       busy;
  logic       chan;
  logic [4:0] cnt;
  logic [7:0] junk;
  always_ff @(posedge clk_i) begin
    done_o  <= 1'b0;
    junk    <= rst_i ? 8'h00 : junk + 8'h5B;
    code_o  <= ~junk;
    under_o <= junk[0];
    if (rst_i || abort_i) begin
      busy <= 1'b0;
    end else if (start_i) begin
      busy <= 1'b1;
      chan <= channel_i;
      cnt  <= delay_i;
    end else if (busy) begin
      if (cnt == 5'h00) begin
        busy    <= 1'b0;
        done_o  <= 1'b1;
        code_o  <= chan ? remote_code_i : local_code_i;
        under_o <= chan & short_i;
      end else begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule : converter_model
`default_nettype wire

/* test/test_standby_and_sensor_fault_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tsense_params.svh"
module test_standby_and_sensor_fault_ctrl;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        hold_n = 1'b1;
  logic        scl = 1'b1;
  logic        sda_low = 1'b0;
  logic        open_cmp = 1'b0;
  logic        short = 1'b0;
  logic        sda_oe, sdo, alert_oe, start, chan, abort, done, under;
  logic [7:0]  code, v;
  logic [7:0]  lcode = 8'h19;
  logic [7:0]  rcode = 8'h2D;
  logic [4:0]  dly = 5'h03;
  logic [31:0] seed = 32'h79224735;
  int          num_errors = 0;
  int          check_count = 0;
  int          starts = 0;
  int          aborts = 0;
  int          base;
  // Open drain: the line only falls where a driver is enabled with a low level.
  wire         sda = ~sda_low & (~sda_oe | sdo);

  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (start === 1'b1) starts++;
    if (abort === 1'b1) aborts++;
  end

  standby_and_sensor_fault_ctrl #(.CONV_GAP(16'h0002)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .low_power_hold_n_i(hold_n), .scl_i(scl),
    .serial_data_line_i(sda), .serial_data_line_o(sdo), .serial_data_line_oe_o(sda_oe),
    .alert_o(), .alert_oe_o(alert_oe), .adc_start_o(start), .adc_channel_o(chan),
    .adc_abort_o(abort), .adc_done_i(done), .adc_code_i(code), .adc_under_range_i(under),
    .open_cmp_i(open_cmp));
  converter_model i_conv (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .channel_i(chan), .abort_i(abort),
    .local_code_i(lcode), .remote_code_i(rcode), .short_i(short), .delay_i(dly),
    .done_o(done), .code_o(code), .under_o(under));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [7:0] exp_remote(input logic [7:0] c, input logic s);
    return s ? `SHORT_CODE : c;
  endfunction : exp_remote

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic half;
    repeat (4) @(negedge clk_i);
  endtask : half
  // The bus is slow next to the core clock: the clock stands low eight core cycles and high four.
  task automatic clk_bit(input logic b, output logic s);
    half;
    sda_low = ~b;
    half;
    scl = 1'b1;
    half;
    s = sda;
    scl = 1'b0;
  endtask : clk_bit
  task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx, output logic s9);
    for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
    clk_bit(b9, s9);
  endtask : xfer
  task automatic start_c;
    sda_low = 1'b0;
    scl = 1'b1;
    half;
    sda_low = 1'b1;
    half;
    scl = 1'b0;
  endtask : start_c
  task automatic stop_c;
    half;
    sda_low = 1'b1;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b0;
    half;
  endtask : stop_c
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    logic       a;
    start_c;
    xfer({`DEV_ADDR, 1'b0}, 1'b1, r, a);
    check("address ack", {7'h00, a}, 8'h00);
    xfer(p, 1'b1, r, a);
    xfer(d, 1'b1, r, a);
    check("data ack", {7'h00, a}, 8'h00);
    stop_c;
  endtask : wr
  task automatic chk_reg(input string name, input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] r;
    logic       a;
    start_c;
    xfer({`DEV_ADDR, 1'b0}, 1'b1, r, a);
    xfer(p, 1'b1, r, a);
    stop_c;
    start_c;
    xfer({`DEV_ADDR, 1'b1}, 1'b1, r, a);
    xfer(8'hFF, 1'b1, r, a);
    stop_c;
    check(name, r, exp);
  endtask : chk_reg
  task automatic ara;
    logic [7:0] r;
    logic       a;
    start_c;
    xfer({`ARA_ADDR, 1'b1}, 1'b1, r, a);
    xfer(8'hFF, 1'b1, r, a);
    stop_c;
    check("alert response", r, {`DEV_ADDR, 1'b0});
  endtask : ara
  // The caller gives the base, so starts that fire inside a bus task are not missed.
  task automatic wait_starts(input int b, input int n);
    for (int i = 0; i < 3000 && starts < b + n; i++) @(negedge clk_i);
    if (starts < b + n) begin
      num_errors++;
      $display("[FAIL] start wait expected %0d seen %0d", n, starts - b);
      print_verdict;
    end
  endtask : wait_starts

  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    chk_reg("remote low limit", `REG_RLO, `LIM_LO_RST);
    chk_reg("config", `REG_CFG, 8'h00);
    $display("test reset done");
    seed = xs(seed);
    lcode = {2'b00, seed[5:0]};
    rcode = {2'b00, seed[13:8]};
    dly = seed[20:16];
    wait_starts(starts, 3);
    chk_reg("local", `REG_LOCAL, lcode);
    chk_reg("remote", `REG_REMOTE, exp_remote(rcode, 1'b0));
    $display("test normal done");
    wr(`REG_CFG, 8'h40);
    base = starts;
    v = rcode;
    seed = xs(seed);
    rcode = {2'b00, seed[5:0]};
    repeat (200) @(negedge clk_i);
    check("standby starts", 8'(starts - base), 8'h00);
    chk_reg("remote held", `REG_REMOTE, v);
    wr(`REG_ONESHOT, seed[15:8]);
    wait_starts(base, 2);
    repeat (300) @(negedge clk_i);
    check("one-shot starts", 8'(starts - base), 8'h02);
    chk_reg("one-shot remote", `REG_REMOTE, rcode);
    $display("test software standby done");
    wr(`REG_CFG, 8'h00);
    dly = 5'h14;
    wait_starts(starts, 1);
    base = aborts;
    hold_n = 1'b0;
    v = lcode;
    lcode = lcode + 8'h01;
    rcode = rcode + 8'h01;
    repeat (4) @(negedge clk_i);
    check("abort pulse", 8'(aborts - base), 8'h01);
    base = starts;
    wr(`REG_ONESHOT, 8'hA5);
    repeat (300) @(negedge clk_i);
    check("pin standby starts", 8'(starts - base), 8'h00);
    wr(`REG_LHI, {2'b01, seed[21:16]});
    chk_reg("limit in standby", `REG_LHI, {2'b01, seed[21:16]});
    chk_reg("local held", `REG_LOCAL, v);
    chk_reg("remote held", `REG_REMOTE, rcode - 8'h01);
    hold_n = 1'b1;
    $display("test hardware standby done");
    open_cmp = 1'b1;
    wait_starts(starts, 2);
    check("alarm open", {7'h00, alert_oe}, 8'h01);
    chk_reg("status open", `REG_STATUS, 8'h04);
    ara;
    check("alarm kept", {7'h00, alert_oe}, 8'h01);
    open_cmp = 1'b0;
    wait_starts(starts, 2);
    chk_reg("status clear", `REG_STATUS, 8'h04);
    chk_reg("status idle", `REG_STATUS, 8'h00);
    check("alarm latched", {7'h00, alert_oe}, 8'h01);
    ara;
    check("alarm released", {7'h00, alert_oe}, 8'h00);
    $display("test open sensor done");
    short = 1'b1;
    wait_starts(starts, 2);
    chk_reg("short code", `REG_REMOTE, exp_remote(rcode, short));
    check("alarm short", {7'h00, alert_oe}, 8'h01);
    wr(`REG_RLO, `SHORT_CODE);
    chk_reg("status low", `REG_STATUS, 8'h08);
    wait_starts(starts, 2);
    chk_reg("status silenced", `REG_STATUS, 8'h00);
    ara;
    check("alarm silenced", {7'h00, alert_oe}, 8'h00);
    $display("test shorted sensor done");
    print_verdict;
  end
endmodule : test_standby_and_sensor_fault_ctrl
`default_nettype wire
